// [hw/vtbs_pkg.sv]
package vtbs_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [15:0] TRIM_B3_ADDR = 16'h000B;
  localparam logic [15:0] TRIM_B2_ADDR = 16'h000C;
  localparam logic [15:0] TRIM_B1_ADDR = 16'h000D;
  localparam logic [15:0] TRIM_B0_ADDR = 16'h000E;
  localparam logic [15:0] FLAG_ADDR = 16'h0018;
  localparam logic [15:0] STRAP_HI_ADDR = 16'h0019;
  localparam logic [15:0] STRAP_LO_ADDR = 16'h001A;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int FLAG_BIT = 0;
  localparam int STRAP_W = 5;
  localparam logic [31:0] TRIM_RESET = 32'h02769140;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [15:0] STRAP_RESET = 16'h0000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  // cycles for the three-stage pin synchroniser to fill after reset
  localparam logic [1:0] SYNC_FILL = 2'h3;

  // ----------------------------------------
  // management port request
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } vtbs_req_t;

endpackage : vtbs_pkg

// [hw/vtbs_regs.sv]
module vtbs_regs
  import vtbs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // management port byte access
  input vtbs_req_t req,
  output logic [7:0] rd_data_q,
  output logic rd_valid_q,
  // strap pins
  input wire logic [STRAP_W-1:0] strap_pins,
  // to the oscillator control
  output logic [31:0] trim_word_q,
  output logic restart_flag_q,
  output logic strap_valid_q
);

  // ----------------------------------------
  // check defaults
  // ----------------------------------------
  // one clock domain, so one default serves every check in this module
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  logic [3:0] wr_trim;
  logic wr_flag;
  logic [7:0] trim_byte_q [4];
  assign wr_flag = req.wr && (req.addr == FLAG_ADDR);

  // ----------------------------------------
  // trim word
  // ----------------------------------------
  // signed offset; the analog side scales the divider product by 1 + X*2^-32
  // no shadow copy: while the host rewrites the word the bytes mix old and new
  for (genvar b = 0; b < 4; b++) begin : g_trim
    // most significant byte at the lowest address
    assign wr_trim[b] = req.wr && (req.addr == TRIM_B0_ADDR - 16'(b));

    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        trim_byte_q[b] <= TRIM_RESET[8*b +: 8];
      end else if (wr_trim[b]) begin
        trim_byte_q[b] <= req.data;
      end
    end

    trim_byte_a: assert property (wr_trim[b] |=> trim_byte_q[b] == $past(req.data))
      else $error("trim byte not written");
    trim_keep_a: assert property (!wr_trim[b] |=> $stable(trim_byte_q[b]))
      else $error("trim byte changed without write");
    trim_read_a: assert property (req.rd && (req.addr == TRIM_B0_ADDR - 16'(b)) |=>
      rd_data_q == $past(trim_byte_q[b]))
      else $error("trim byte read mismatch");
  end

  // whole word to the oscillator control, straight from the byte flops
  assign trim_word_q = {trim_byte_q[3], trim_byte_q[2], trim_byte_q[1], trim_byte_q[0]};

  // ----------------------------------------
  // restart-detect flag
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      restart_flag_q <= FLAG_RESET;
    end else if (wr_flag) begin
      restart_flag_q <= req.data[FLAG_BIT];
    end
  end

  // a zero written clears it too; only bit 0 is stored
  flag_clear_a: assert property (wr_flag && !req.data[FLAG_BIT] |=> !restart_flag_q)
    else $error("flag not cleared by write");

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  // three stages since the pins are not timed to core_clk
  logic [STRAP_W-1:0] sync1_q, sync2_q, sync3_q;
  logic [1:0] fill_cnt_q;
  logic [STRAP_W-1:0] strap_q;
  logic cap_fire;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= strap_pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fill_cnt_q <= 2'h0;
    end else if (fill_cnt_q != SYNC_FILL) begin
      fill_cnt_q <= fill_cnt_q + 2'h1;
    end
  end

  // pins still moving after release delay the capture until two stages agree
  assign cap_fire = !strap_valid_q && (fill_cnt_q == SYNC_FILL) && (sync2_q == sync3_q);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      strap_q <= STRAP_RESET[STRAP_W-1:0];
      strap_valid_q <= 1'b0;
    end else if (cap_fire) begin
      strap_q <= sync3_q;
      strap_valid_q <= 1'b1;
    end
  end

  strap_wait_a: assert property (!strap_valid_q && !cap_fire |=> !strap_valid_q)
    else $error("strap taken too early");
  strap_settle_a: assert property (!strap_valid_q && fill_cnt_q == SYNC_FILL && sync2_q == sync3_q |=> strap_valid_q)
    else $error("strap not taken once settled");

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [15:0] strap_word;
  logic [7:0] rd_mux;
  assign strap_word = {{(16 - STRAP_W){1'b0}}, strap_q};

  always_comb begin
    case (req.addr)
      TRIM_B3_ADDR: rd_mux = trim_word_q[31:24];
      TRIM_B2_ADDR: rd_mux = trim_word_q[23:16];
      TRIM_B1_ADDR: rd_mux = trim_word_q[15:8];
      TRIM_B0_ADDR: rd_mux = trim_word_q[7:0];
      FLAG_ADDR: rd_mux = {7'h00, restart_flag_q};
      STRAP_HI_ADDR: rd_mux = strap_word[15:8];
      STRAP_LO_ADDR: rd_mux = strap_word[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= req.rd;
      if (req.rd) rd_data_q <= rd_mux;
    end
  end

  logic addr_mapped;
  // anything outside the seven bytes answers zero, so stray polls are harmless
  assign addr_mapped = req.addr inside {TRIM_B3_ADDR, TRIM_B2_ADDR, TRIM_B1_ADDR, TRIM_B0_ADDR, FLAG_ADDR,
    STRAP_HI_ADDR, STRAP_LO_ADDR};

  rd_pulse_a: assert property (req.rd |=> rd_valid_q)
    else $error("read not answered");
  rd_idle_a: assert property (!req.rd |=> !rd_valid_q)
    else $error("read answer without request");
  // data holds its last value so a slow host may still pick it up
  rd_hold_a: assert property (!req.rd |=> $stable(rd_data_q))
    else $error("read data moved without request");
  flag_read_a: assert property (req.rd && req.addr == FLAG_ADDR |=> rd_data_q[0] == $past(restart_flag_q))
    else $error("flag read mismatch");
  rd_unmapped_a: assert property (req.rd && !addr_mapped |=> rd_data_q == 8'h00)
    else $error("unmapped read not zero");

  // ----------------------------------------
  // reset state checks
  // ----------------------------------------
  // low only at the first edge after release, the one edge that shows pure reset state
  logic run_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
    end else begin
      run_q <= 1'b1;
    end
  end

  flag_reset_a: assert property (!run_q |-> !restart_flag_q)
    else $error("flag not cleared by reset");
  trim_reset_a: assert property (!run_q |-> trim_word_q == TRIM_RESET)
    else $error("trim not at reset value");
  strap_reset_a: assert property (!run_q |-> !strap_valid_q && strap_q == STRAP_RESET[STRAP_W-1:0])
    else $error("strap not empty after reset");

  // ----------------------------------------
  // checks
  // ----------------------------------------
  flag_set_a: assert property (wr_flag && req.data[FLAG_BIT] |=> restart_flag_q)
    else $error("flag not set by write");
  flag_hold_a: assert property (restart_flag_q && !wr_flag |=> restart_flag_q)
    else $error("flag lost without reset or write");
  flag_zero_a: assert property (!restart_flag_q && !wr_flag |=> !restart_flag_q)
    else $error("flag rose without write");
  trim_hold_a: assert property (!(|wr_trim) |=> $stable(trim_word_q))
    else $error("trim changed without write");
  strap_take_a: assert property (cap_fire |=> strap_q == $past(sync3_q) && strap_valid_q)
    else $error("strap capture wrong");
  strap_once_a: assert property (strap_valid_q |=> $stable(strap_q) && strap_valid_q)
    else $error("strap changed after capture");
  flag_rsvd_a: assert property (req.rd && req.addr == FLAG_ADDR |=> rd_valid_q && rd_data_q[7:1] == 7'h00)
    else $error("flag reserved bits not zero");
  strap_rsvd_a: assert property (req.rd && req.addr == STRAP_HI_ADDR |=> rd_data_q == 8'h00)
    else $error("strap high byte not zero");
  strap_pos_a: assert property (req.rd && req.addr == STRAP_LO_ADDR |=> rd_data_q == {3'h0, $past(strap_q)})
    else $error("strap read mismatch");

  flag_poll_c: cover property (wr_flag ##[1:20] (req.rd && req.addr == FLAG_ADDR));
  trim_load_c: cover property (wr_trim[3] ##[1:8] wr_trim[0]);
  strap_cap_c: cover property (cap_fire && sync3_q != '0);
  trim_neg_c: cover property (wr_trim[3] && req.data[7]);
  flag_clear_c: cover property (restart_flag_q && wr_flag && !req.data[FLAG_BIT]);

endmodule : vtbs_regs

// [bench/vtbs_host.sv]
module vtbs_host
  import vtbs_pkg::*;
(
  // clock
  input wire logic core_clk,
  // management port
  output vtbs_req_t req,
  input wire logic [7:0] rd_data_q,
  input wire logic rd_valid_q
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // one byte access: drive after a falling edge, drop one cycle later
  task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk);
    req <= '{wr: w, rd: !w, addr: a, data: d};
    @(negedge core_clk);
    req <= '0;
    q = rd_data_q;
  endtask : access
endmodule : vtbs_host

// [bench/vtbs_regs_bench.sv]
module vtbs_regs_bench;
  import vtbs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0;
  logic nrst = 0;
  logic [4:0] pins = '0;
  logic [4:0] p;
  vtbs_req_t req;
  logic [7:0] rd_data_q, q;
  logic rd_valid_q, restart_flag_q, strap_valid_q;
  logic [31:0] trim_word_q, x;
  int err_count = 0;
  int samples_checked = 0;
  integer seed = 32'h02e535b8;
  initial forever #25 core_clk = ~core_clk;
  vtbs_regs uut (.core_clk(core_clk), .nrst(nrst), .req(req), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .strap_pins(pins), .trim_word_q(trim_word_q), .restart_flag_q(restart_flag_q), .strap_valid_q(strap_valid_q));
  vtbs_host host (.core_clk(core_clk), .req(req), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wrap_up;
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task rd(input logic [15:0] a, input logic [7:0] exp);
    host.access(1'b0, a, 8'h00, q);
    check(rd_valid_q, 1'b1);
    check(q, exp);
  endtask : rd
  task wr(input logic [15:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
  endtask : wr
  // pins held steady from reset until the capture is seen
  task do_reset(input logic [4:0] v);
    pins = v;
    nrst = 0;
    repeat (8) @(negedge core_clk);
    nrst = 1;
    for (int n = 0; n < 20 && strap_valid_q !== 1'b1; n++) @(negedge core_clk);
    if (strap_valid_q !== 1'b1) begin
      err_count++;
      wrap_up();
    end
  endtask : do_reset
  // host side stays inside the tuning range, sign opposite to the error
  function automatic logic [31:0] trim_for(input int k);
    if (k == 0) return -32'sd42949672;
    if (k == 1) return 32'sd42949672;
    return $random(seed) % 42949673;
  endfunction : trim_for
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    p = 5'($random(seed));
    do_reset(p);
    check(strap_valid_q, 1'b1);
    rd(STRAP_LO_ADDR, {3'h0, p});
    rd(STRAP_HI_ADDR, 8'h00);
    pins = ~p;
    rd(FLAG_ADDR, 8'h00);
    for (int i = 0; i < 4; i++) rd(TRIM_B3_ADDR + 16'(i), TRIM_RESET[31-8*i -: 8]);
    wr(FLAG_ADDR, 8'hFF);
    wr(STRAP_LO_ADDR, 8'h1F);
    wr(16'h0010, 8'hA5);
    rd(FLAG_ADDR, 8'h01);
    check(restart_flag_q, 1'b1);
    rd(16'h0010, 8'h00);
    rd(STRAP_LO_ADDR, {3'h0, p});
    for (int k = 0; k < 20; k++) begin
      x = trim_for(k);
      for (int i = 0; i < 4; i++) wr(TRIM_B3_ADDR + 16'(i), x[31-8*i -: 8]);
      check(trim_word_q, x);
      rd(TRIM_B3_ADDR + 16'(k % 4), x[31-8*(k%4) -: 8]);
      rd(FLAG_ADDR, 8'h01);
    end
    // a zero written clears the flag; then arm it again for the reset check
    wr(FLAG_ADDR, 8'hFE);
    rd(FLAG_ADDR, 8'h00);
    check(restart_flag_q, 1'b0);
    wr(FLAG_ADDR, 8'h01);
    check(restart_flag_q, 1'b1);
    p = 5'($random(seed));
    do_reset(p);
    rd(FLAG_ADDR, 8'h00);
    check(trim_word_q, TRIM_RESET);
    rd(STRAP_LO_ADDR, {3'h0, p});
    wrap_up();
  end
endmodule : vtbs_regs_bench
